// file: verilog/adc_params.svh
// Register indices, field positions, reset values and timing counts
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL        10'h0B6
`define IDX_RES_HIGH    10'h0B7
`define IDX_CONV_CFG    10'h0B8
`define IDX_PIN_ISO     10'h0B9
`define IDX_IRQ_STATUS  10'h0BA
`define IDX_IRQ_MASK    10'h0BB

// Control register fields
`define CTRL_EN_BIT     7
`define CTRL_START_BIT  6
`define CTRL_EOC_BIT    5
`define CTRL_GIE_BIT    4
`define CTRL_CHS_MSB    3

// Conversion config register fields
`define CFG_CKS_MSB     7
`define CFG_CKS_LSB     5
`define CFG_RES_BIT     4

// Reset values
`define RST_CTRL        8'h00
`define RST_CONV_CFG    4'h0
`define RST_PIN_ISO     8'h00
`define RST_IRQ         1'h0

// Channel codes for the two reference inputs
`define CHS_GROUND      4'h8
`define CHS_SUPPLY      4'h9

// Conversion length in quarter-rate converter periods
`define TICKS_12BIT     7'h10
`define TICKS_8BIT      7'h0C
`define QUARTER_DIV     2

`endif

// file: verilog/adc_pkg.sv
// Types shared by the conversion sequencer modules
package adc_pkg;

  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } conv_state_t;

  typedef logic [2:0]  clk_sel_t;
  typedef logic [11:0] conv_word_t;

endpackage

// file: verilog/conv_if.sv
// Control link between the register front end and the conversion timer
`timescale 1ns/100ps
interface conv_if;
  logic start;
  logic abort;
  logic res12;
  logic tick;
  logic done;
  logic busy;

  modport ctl (output start, output abort, output res12, output tick,
               input done, input busy);
  modport tmr (input start, input abort, input res12, input tick,
               output done, output busy);
endinterface

// file: verilog/conv_clk_div.sv
// Converter clock enable divider from the CPU clock
`timescale 1ns/100ps
`include "adc_params.svh"
module conv_clk_div
  import adc_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire clk_sel_t sel,
  output logic          tick
);

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       tick_nxt;

  // Divide ratio for each select code; zero marks the reserved code
  function automatic logic [6:0] div_of(input clk_sel_t s);
    case (s)
      3'h0:    div_of = 7'h10;
      3'h1:    div_of = 7'h08;
      3'h2:    div_of = 7'h01;
      3'h3:    div_of = 7'h02;
      3'h4:    div_of = 7'h40;
      3'h5:    div_of = 7'h20;
      3'h6:    div_of = 7'h04;
      default: div_of = 7'h00;
    endcase
  endfunction

  // divide select
  // Reserved code gives no ticks, so a conversion simply waits
  always_comb begin
    logic [6:0] d;
    d        = div_of(sel);
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 6'h01;
    if (d == 7'h00) begin
      cnt_nxt = 6'h00;
    end else if ({1'b0, cnt_r} >= d - 7'h01) begin
      cnt_nxt  = 6'h00;
      tick_nxt = 1'b1;
    end
  end

  // Counter and tick flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 6'h00;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

  // Spacing checks for two divide ratios with a steady select
  a_div8_spacing: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && sel == 3'h1 && $stable(sel)) ##1 (sel == 3'h1)[*8]
      |-> $past(tick, 8) && tick)
    else $error("divide by 8 tick spacing wrong");
  a_div4_spacing: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && sel == 3'h6) ##1 (sel == 3'h6)[*4] |-> tick && !$past(tick))
    else $error("divide by 4 tick spacing wrong");

endmodule // conv_clk_div

// file: verilog/conv_timer.sv
// Conversion timer counting converter clock ticks to completion
`timescale 1ns/100ps
`include "adc_params.svh"
module conv_timer
  import adc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  conv_if.tmr       cv
);

  conv_state_t state_r;
  conv_state_t state_nxt;
  logic [6:0]  cnt_r;
  logic [6:0]  cnt_nxt;
  logic [6:0]  last;

  assign last = (cv.res12 ? (`TICKS_12BIT << `QUARTER_DIV)
                          : (`TICKS_8BIT << `QUARTER_DIV)) - 7'h01;

  // Done is combinational so completion lands on the final tick edge
  assign cv.done = (state_r == ST_CONV) && cv.tick && (cnt_r == last)
                   && !cv.start && !cv.abort;
  assign cv.busy = (state_r == ST_CONV);

  // Next state: a new start always restarts the count
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (cv.start) begin
          state_nxt = ST_CONV;
          cnt_nxt   = 7'h00;
        end
      end
      ST_CONV: begin
        if (cv.start) begin
          cnt_nxt = 7'h00;
        end else if (cv.abort || cv.done) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = 7'h00;
        end else if (cv.tick) begin
          cnt_nxt = cnt_r + 7'h01;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt   = 7'h00;
      end
    endcase
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 7'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  a_no_done_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    cv.done |=> state_r == ST_IDLE && cnt_r == 7'h00)
    else $error("timer did not stop at completion");

endmodule // conv_timer

// file: verilog/adc_sequencer.sv
// Converter sequencer top: APB registers, timing, result and interrupt
// Behaviour
// - Conversion time runs from the start-bit write to the end flag rising.
// - A 12-bit conversion lasts 16 quarter-rate periods, 64 converter clocks.
// - An 8-bit conversion lasts 12 quarter-rate periods, 48 converter clocks.
// - A set isolation bit cuts that pin's digital path and pull-up.
// - Writing start while enabled begins conversion of the chosen channel.
// - Completion sets the end flag and, when unmasked, the interrupt request.
// - Hardware clears the start bit when a conversion finishes.
// - The end flag tracks status at once and clears when start is set.
// - Channel codes 0-7 pick analog inputs, 8 ground and 9 supply.
// - Clock select codes 0-6 divide by 16, 8, 1, 2, 64, 32, 4; 7 reserved.
// - Result bits 11:4 go high, 3:0 low nibble; 8-bit keeps high byte only.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_params.svh"
module adc_sequencer
  import adc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire conv_word_t  conv_result,
  output logic             core_power_on,
  output logic             core_sample,
  output logic             core_clk_en,
  output logic      [9:0]  mux_select,
  output logic      [7:0]  pin_analog_isolate,
  output logic             converter_irq_request
);

  // Control and configuration state
  logic       converter_enable_r, converter_enable_nxt;
  logic       start_conversion_r, start_conversion_nxt;
  logic       eoc_r, eoc_nxt;
  logic       global_input_enable_r, global_input_enable_nxt;
  logic [3:0] channel_select_r, channel_select_nxt;
  clk_sel_t   conv_clock_select_r, conv_clock_select_nxt;
  logic       resolution_select_r, resolution_select_nxt;
  logic [7:0] iso_nxt;
  conv_word_t result_r, result_nxt;
  logic       irq_status_r, irq_status_nxt;
  logic       irq_mask_r, irq_mask_nxt;
  logic       irq_nxt;
  logic [9:0] mux_nxt;

  // Bus front end
  logic [31:0] rdata_nxt;
  logic        slverr_nxt;
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic [9:0]  idx;
  logic        mapped;

  conv_if cv ();

  // One-hot input select; nothing connects while global input is off
  function automatic logic [9:0] mux_of(input logic gie,
                                        input logic [3:0] channel_select);
    mux_of = 10'h000;
    if (gie && channel_select <= `CHS_SUPPLY) begin
      mux_of[channel_select] = 1'b1;
    end
  endfunction

  assign idx    = paddr[11:2];
  assign access = psel && penable && pready;
  assign wr_en  = access && pwrite;
  assign rd_en  = access && !pwrite;
  assign mapped = (idx >= `IDX_CTRL) && (idx <= `IDX_IRQ_MASK);

  // start on write
  // Start only counts while enabled; a write with start low stops it
  assign cv.start = wr_en && idx == `IDX_CTRL
                    && pwdata[`CTRL_START_BIT] && pwdata[`CTRL_EN_BIT];
  assign cv.abort = (wr_en && idx == `IDX_CTRL && !cv.start)
                    || !converter_enable_r;
  assign cv.res12 = resolution_select_r;

  // Next values of the control registers, completion and writes
  always_comb begin
    converter_enable_nxt    = converter_enable_r;
    start_conversion_nxt    = start_conversion_r;
    eoc_nxt                 = eoc_r;
    global_input_enable_nxt = global_input_enable_r;
    channel_select_nxt      = channel_select_r;
    conv_clock_select_nxt   = conv_clock_select_r;
    resolution_select_nxt   = resolution_select_r;
    iso_nxt                 = pin_analog_isolate;
    result_nxt              = result_r;
    irq_mask_nxt            = irq_mask_r;
    if (cv.done) begin
      start_conversion_nxt = 1'b0;
      eoc_nxt              = 1'b1;
      result_nxt = resolution_select_r ? conv_result
                                       : {conv_result[11:4], 4'h0};
    end
    if (wr_en) begin
      case (idx)
        `IDX_CTRL: begin
          converter_enable_nxt    = pwdata[`CTRL_EN_BIT];
          global_input_enable_nxt = pwdata[`CTRL_GIE_BIT];
          channel_select_nxt      = pwdata[`CTRL_CHS_MSB:0];
          start_conversion_nxt    = cv.start;
          if (cv.start) begin
            eoc_nxt = 1'b0;
          end
        end
        `IDX_CONV_CFG: begin
          conv_clock_select_nxt = pwdata[`CFG_CKS_MSB:`CFG_CKS_LSB];
          resolution_select_nxt = pwdata[`CFG_RES_BIT];
        end
        `IDX_PIN_ISO:  iso_nxt      = pwdata[7:0];
        `IDX_IRQ_MASK: irq_mask_nxt = pwdata[0];
        default: ;
      endcase
    end
  end

  // Sticky status: a read clears it, but a same-cycle completion wins
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (rd_en && idx == `IDX_IRQ_STATUS) begin
      irq_status_nxt = 1'b0;
    end
    if (cv.done) begin
      irq_status_nxt = 1'b1;
    end
    irq_nxt = irq_status_r && irq_mask_r;
  end

  assign mux_nxt = mux_of(global_input_enable_nxt, channel_select_nxt);

  // Read data is captured in the setup cycle, so pready needs no wait state
  always_comb begin
    rdata_nxt  = 32'h0000_0000;
    slverr_nxt = 1'b0;
    if (psel && !penable) begin
      slverr_nxt = !mapped;
      case (idx)
        `IDX_CTRL: rdata_nxt[7:0] = {converter_enable_r, start_conversion_r,
                                     eoc_r, global_input_enable_r,
                                     channel_select_r};
        `IDX_RES_HIGH: rdata_nxt[7:0] = result_r[11:4];
        `IDX_CONV_CFG: rdata_nxt[7:0] = {conv_clock_select_r,
                                         resolution_select_r,
                                         result_r[3:0]};
        `IDX_IRQ_STATUS: rdata_nxt[0] = irq_status_r;
        `IDX_IRQ_MASK:   rdata_nxt[0] = irq_mask_r;
        default: ;
      endcase
    end
  end

  // Register bank; isolation register is write-only and reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {converter_enable_r, start_conversion_r, eoc_r,
       global_input_enable_r, channel_select_r} <= `RST_CTRL;
      {conv_clock_select_r, resolution_select_r} <= `RST_CONV_CFG;
      pin_analog_isolate    <= `RST_PIN_ISO;
      result_r              <= 12'h000;
      irq_status_r          <= `RST_IRQ;
      irq_mask_r            <= `RST_IRQ;
      converter_irq_request <= 1'b0;
      mux_select            <= 10'h000;
      core_power_on         <= 1'b0;
      core_sample           <= 1'b0;
      prdata                <= 32'h0000_0000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
    end else begin
      converter_enable_r    <= converter_enable_nxt;
      start_conversion_r    <= start_conversion_nxt;
      eoc_r                 <= eoc_nxt;
      global_input_enable_r <= global_input_enable_nxt;
      channel_select_r      <= channel_select_nxt;
      conv_clock_select_r   <= conv_clock_select_nxt;
      resolution_select_r   <= resolution_select_nxt;
      pin_analog_isolate    <= iso_nxt;
      result_r              <= result_nxt;
      irq_status_r          <= irq_status_nxt;
      irq_mask_r            <= irq_mask_nxt;
      converter_irq_request <= irq_nxt;
      mux_select            <= mux_nxt;
      core_power_on         <= converter_enable_nxt;
      core_sample           <= start_conversion_nxt;
      prdata                <= rdata_nxt;
      pready                <= psel && !penable;
      pslverr               <= slverr_nxt;
    end
  end

  // Converter clock enable and conversion timer
  conv_clk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (conv_clock_select_r),
    .tick    (cv.tick)
  );
  assign core_clk_en = cv.tick;

  conv_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .cv      (cv)
  );

  // Cycles since the last start, only read by the timing checks
  logic [12:0] meas_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_r <= 13'h0000;
    end else if (cv.start) begin
      meas_r <= 13'h0000;
    end else if (meas_r != 13'h1FFF) begin
      meas_r <= meas_r + 13'h0001;
    end
  end

  sequence s_start_write;
    wr_en && idx == `IDX_CTRL && pwdata[`CTRL_START_BIT]
      && pwdata[`CTRL_EN_BIT];
  endsequence

  sequence s_finish;
    cv.done && !cv.start;
  endsequence

  a_start_clears_eoc: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_start_write |=> start_conversion_r && !eoc_r && core_sample && cv.busy)
    else $error("start did not set busy and clear end flag");

  a_done_sets_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_finish |=> eoc_r && !start_conversion_r && irq_status_r)
    else $error("completion flags wrong");

  a_result_update: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_finish ##1 eoc_r |-> result_r[11:4] == $past(conv_result[11:4]))
    else $error("result not updated with end flag");

  a_low_nibble_8bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_finish and !resolution_select_r) |=> result_r[3:0] == 4'h0)
    else $error("8-bit result low nibble not cleared");

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_finish ##1 irq_mask_r |=> converter_irq_request)
    else $error("unmasked completion raised no interrupt");

  a_isolate_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && idx == `IDX_PIN_ISO |=> pin_analog_isolate == $past(pwdata[7:0]))
    else $error("isolation bits not applied");

  a_mux_ground: assert property (
    @(posedge pclk) disable iff (!presetn)
    global_input_enable_r && channel_select_r == `CHS_GROUND
      ##1 ($stable(channel_select_r) && global_input_enable_r)
      |-> mux_select == 10'h100)
    else $error("ground select not decoded");

  a_time_12bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_finish and (conv_clock_select_r == 3'h2 && resolution_select_r
      && $stable(conv_clock_select_r)) |-> meas_r == 13'h003F)
    else $error("12-bit conversion not 64 converter clocks");

  a_time_8bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_finish and (conv_clock_select_r == 3'h2 && !resolution_select_r
      && $stable(conv_clock_select_r)) |-> meas_r == 13'h002F)
    else $error("8-bit conversion not 48 converter clocks");

endmodule // adc_sequencer

// file: verif/core_model.sv
// Behavioural converter core: hands back a channel-dependent result
`timescale 1ns/100ps
module core_model
  import adc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       core_power_on,
  input  wire logic       core_sample,
  input  wire logic [9:0] mux_select,
  output conv_word_t      conv_result
);
  logic [3:0] chan_idx;

  // Decode the one-hot selection; no selection gives code F
  always_comb begin
    chan_idx = 4'hF;
    for (int i = 0; i < 10; i++) begin
      if (mux_select[i]) begin
        chan_idx = i[3:0];
      end
    end
  end

  // pure analog input
  // Valid result only while powered and sampling; otherwise the value
  // toggles every cycle so a stale capture cannot look right by chance
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_result <= 12'hA5A;
    end else if (core_power_on && core_sample) begin
      conv_result <= {chan_idx, 8'hC5};
    end else begin
      conv_result <= ~conv_result;
    end
  end
endmodule // core_model

// file: verif/tb.sv
// Self-checking bench for the conversion sequencer over APB
`timescale 1ns/100ps
`include "adc_params.svh"
module tb;
  import adc_pkg::*;
  localparam logic [11:0] A_CTRL = {`IDX_CTRL, 2'b00};
  localparam logic [11:0] A_HIGH = {`IDX_RES_HIGH, 2'b00};
  localparam logic [11:0] A_CFG  = {`IDX_CONV_CFG, 2'b00};
  localparam logic [11:0] A_ISO  = {`IDX_PIN_ISO, 2'b00};
  localparam logic [11:0] A_STAT = {`IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MASK = {`IDX_IRQ_MASK, 2'b00};
  localparam int          WARM   = 10000;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  conv_word_t  conv_result;
  logic        core_power_on;
  logic        core_sample;
  logic        core_clk_en;
  logic [9:0]  mux_select;
  logic [7:0]  pin_analog_isolate;
  logic        converter_irq_request;
  int          miscompares;
  int          cmp_count;
  int          samp_cnt;
  int          tick_cnt;
  int          t7;
  logic [31:0] r;
  logic        e;
  int          divs [7] = '{16, 8, 1, 2, 64, 32, 4};

  adc_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_result(conv_result), .core_power_on(core_power_on),
    .core_sample(core_sample), .core_clk_en(core_clk_en),
    .mux_select(mux_select), .pin_analog_isolate(pin_analog_isolate),
    .converter_irq_request(converter_irq_request));

  core_model i_core (.pclk(pclk), .presetn(presetn),
    .core_power_on(core_power_on), .core_sample(core_sample),
    .mux_select(mux_select), .conv_result(conv_result));

  // Free-running clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Counts cycles and converter clocks spent sampling, to time conversions
  always @(posedge pclk) begin
    if (core_sample === 1'b1) begin
      samp_cnt <= samp_cnt + 1;
    end
    if (core_sample === 1'b1 && core_clk_en === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd_v,
                     output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, {24'h0, d}, x, y);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic y;
    apb(1'b0, a, 32'h0, d, y);
  endtask

  // Start one conversion, time it and check flags and result
  task automatic conv(input logic [2:0] cks, input logic r12,
                      input logic [3:0] ch, input int div);
    int         base;
    int         n;
    int         len;
    int         tk;
    int         tbase;
    conv_word_t exp;
    tk  = r12 ? 64 : 48;
    exp = {ch, 8'hC5};
    wr(A_CFG, {cks, r12, 4'h0});
    base  = samp_cnt;
    tbase = tick_cnt;
    wr(A_CTRL, {4'hD, ch});
    rd(A_CTRL, r);
    chk("ctrl_busy", r, {24'h0, 4'hD, ch});
    n = 0;
    while (core_sample !== 1'b0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    len = samp_cnt - base;
    chk("conv_ticks", tick_cnt - tbase, tk);
    if (div == 1) begin
      chk("conv_len", len, tk);
    end else begin
      chk("conv_len_rng", (len >= tk * div - div && len <= tk * div + div), 1);
    end
    rd(A_CTRL, r);
    chk("ctrl_done", r, {24'h0, 4'hB, ch});
    rd(A_HIGH, r);
    chk("res_high", r, {24'h0, exp[11:4]});
    rd(A_CFG, r);
    chk("res_low", r, {24'h0, cks, r12, r12 ? exp[3:0] : 4'h0});
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #600000;
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    miscompares = 0;
    cmp_count   = 0;
    samp_cnt    = 0;
    tick_cnt    = 0;
    t7          = 0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values read from control, isolation, status, mask and config registers
    foreach (divs[k]) begin
      if (k < 4) begin
        rd(k == 0 ? A_CTRL : k == 1 ? A_ISO : k == 2 ? A_STAT : A_MASK, r);
        chk("reg_rst", r, 32'h0);
      end
    end
    rd(A_CFG, r);
    chk("cfg_rst", r & 32'hF0, 32'h0);
    chk("irq_rst", converter_irq_request, 1'b0);
    apb(1'b0, 12'h300, 32'h0, r, e);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_rd", r, 32'h0);
    wr(A_CTRL, 8'h50);
    repeat (5) @(posedge pclk);
    chk("start_no_en", core_sample, 1'b0);
    wr(A_ISO, 8'hA5);
    repeat (2) @(posedge pclk);
    chk("iso_pins", pin_analog_isolate, 8'hA5);
    rd(A_ISO, r);
    chk("iso_rd", r, 32'h0);
    // Warm-up once after enabling, never again before later starts
    wr(A_CTRL, 8'h90);
    repeat (WARM) @(posedge pclk);
    chk("power_on", core_power_on, 1'b1);
    for (int c = 0; c < 16; c++) begin
      wr(A_CTRL, {4'h9, c[3:0]});
      repeat (2) @(posedge pclk);
      chk("mux_sel", mux_select, c < 10 ? 10'h1 << c : 10'h0);
    end
    wr(A_CTRL, 8'h83);
    repeat (2) @(posedge pclk);
    chk("mux_gie_off", mux_select, 10'h0);
    wr(A_MASK, 8'h01);
    conv(3'h2, 1'b1, 4'h3, 1);
    chk("irq_set", converter_irq_request, 1'b1);
    rd(A_STAT, r);
    chk("stat_set", r, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_clr", converter_irq_request, 1'b0);
    rd(A_STAT, r);
    chk("stat_clr", r, 32'h0);
    conv(3'h2, 1'b0, 4'h9, 1);
    wr(A_MASK, 8'h00);
    rd(A_STAT, r);
    // Every divider code, masked interrupt must stay low
    foreach (divs[k]) begin
      conv(k[2:0], 1'b0, k[3:0], divs[k]);
    end
    chk("irq_masked", converter_irq_request, 1'b0);
    rd(A_STAT, r);
    chk("stat_masked", r, 32'h1);
    // Reserved code stalls the conversion until software aborts it
    wr(A_CFG, 8'hF0);
    wr(A_CTRL, 8'hD0);
    t7 = tick_cnt;
    repeat (300) @(posedge pclk);
    chk("cks7_hang", core_sample, 1'b1);
    chk("cks7_no_clk", tick_cnt - t7, 0);
    wr(A_CTRL, 8'h90);
    repeat (2) @(posedge pclk);
    chk("abort", core_sample, 1'b0);
    rd(A_CTRL, r);
    chk("abort_ctrl", r, 32'h90);
    test_done();
  end
endmodule // tb
